/* hw/sse_core.sv */
`timescale 1ns/1ns
`include "sse_regs.svh"
module sse_core #(
   parameter int DW = 8
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [15:0] instr,
   input wire logic instr_valid,
   input wire logic ext_set_en,
   input wire logic [3:0] bank_select,
   input wire logic [7:0] fsr2_base,
   input wire logic [DW-1:0] reg_rdata,
   input wire logic carry_in,
   input wire logic wdt_wake,
   input wire logic other_wake,
   output logic [11:0] reg_addr,
   output logic reg_rd,
   output logic reg_wr,
   output logic [DW-1:0] reg_wdata,
   output logic [DW-1:0] acc,
   output logic flag_n,
   output logic flag_ov,
   output logic flag_c,
   output logic flag_dc,
   output logic flag_z,
   output logic power_down_flag,
   output logic watchdog_expiry_flag,
   output logic [7:0] wdt_count,
   output logic [7:0] wdt_post,
   output logic osc_run,
   output logic sleeping,
   output logic busy
);
   // Only the 8-bit datapath and flag logic are built
   if (DW != 8) begin
      $error("sse_core supports only DW = 8");
   end

   // ----------------------------------------
   // Phase and decode state
   // ----------------------------------------
   sse_pkg::sse_phase_t phase_q;
   sse_pkg::sse_op_t op_q;
   logic [7:0] f_q;
   logic [7:0] lit_q;
   logic dest_q;
   logic [DW-1:0] res_q;
   logic [DW:0] diff_d;
   logic [4:0] half_d;
   logic [DW-1:0] a_d;
   logic [DW-1:0] b_d;
   logic bin_d;
   logic ov_d;
   logic is_sleep;

   assign is_sleep = (instr == `SSE_OP_SLEEP);

   always_ff @(posedge clk) begin
      if (reset) begin
         phase_q <= sse_pkg::SSE_Q1;
         busy <= 1'b0;
      end else if (busy) begin
         unique case (phase_q)
            sse_pkg::SSE_Q1: phase_q <= sse_pkg::SSE_Q2;
            sse_pkg::SSE_Q2: phase_q <= sse_pkg::SSE_Q3;
            sse_pkg::SSE_Q3: phase_q <= sse_pkg::SSE_Q4;
            sse_pkg::SSE_Q4: begin
               phase_q <= sse_pkg::SSE_Q1;
               busy <= 1'b0;
            end
         endcase
      end else if (instr_valid && !sleeping && op_d_valid()) begin
         phase_q <= sse_pkg::SSE_Q2;
         busy <= 1'b1;
      end
   end

   function automatic logic op_d_valid();
      op_d_valid = (instr[15:10] == `SSE_OP_RBS)
         || (instr[15:10] == `SSE_OP_RMA)
         || (instr[15:8] == `SSE_OP_LMA);
   endfunction

   // Q1 decode: capture operands
   // Words offered while busy or asleep are dropped, not queued
   always_ff @(posedge clk) begin
      if (reset) begin
         op_q <= sse_pkg::SSE_OP_NONE;
         f_q <= 8'h00;
         lit_q <= 8'h00;
         dest_q <= 1'b0;
      end else if (!busy && instr_valid && !sleeping) begin
         if (instr[15:10] == `SSE_OP_RBS) begin
            op_q <= sse_pkg::SSE_OP_RBS_K;
         end else if (instr[15:10] == `SSE_OP_RMA) begin
            op_q <= sse_pkg::SSE_OP_RMA_K;
         end else if (instr[15:8] == `SSE_OP_LMA) begin
            op_q <= sse_pkg::SSE_OP_LMA_K;
         end else begin
            op_q <= sse_pkg::SSE_OP_NONE;
         end
         f_q <= instr[7:0];
         lit_q <= instr[7:0];
         dest_q <= (instr[15:8] == `SSE_OP_LMA) ? 1'b0 : instr[9];
      end
   end

   // ----------------------------------------
   // Register address formation
   // ----------------------------------------
   logic acc_bit_q;
   always_ff @(posedge clk) begin
      if (reset) begin
         acc_bit_q <= 1'b0;
      end else if (!busy && instr_valid) begin
         acc_bit_q <= instr[8];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         reg_addr <= 12'h000;
      end else if (busy && phase_q == sse_pkg::SSE_Q1) begin
         reg_addr <= reg_addr;
      end else if (busy && phase_q == sse_pkg::SSE_Q2) begin
         if (!acc_bit_q && ext_set_en && f_q <= `SSE_ILO_MAX) begin
            reg_addr <= {4'h0, 8'(fsr2_base + f_q)};
         end else if (!acc_bit_q) begin
            reg_addr <= (f_q[7]) ? {4'hf, f_q} : {4'h0, f_q};
         end else begin
            reg_addr <= {bank_select, f_q};
         end
      end
   end

   // Read strobe lands on the same edge as the address, so it is a Q3 pulse
   always_ff @(posedge clk) begin
      if (reset) begin
         reg_rd <= 1'b0;
      end else begin
         reg_rd <= busy && phase_q == sse_pkg::SSE_Q2
            && op_q != sse_pkg::SSE_OP_LMA_K;
      end
   end

   // ----------------------------------------
   // Subtractor
   // ----------------------------------------
   // One shared subtractor; the opcode picks the operands and whether carry_in borrows
   always_comb begin
      a_d = acc;
      b_d = reg_rdata;
      bin_d = 1'b0;
      unique case (op_q)
         sse_pkg::SSE_OP_RBS_K: begin
            // acc minus f minus not carry
            a_d = acc;
            b_d = reg_rdata;
            bin_d = ~carry_in;
         end
         sse_pkg::SSE_OP_RMA_K: begin
            a_d = reg_rdata;
            b_d = acc;
         end
         sse_pkg::SSE_OP_LMA_K: begin
            a_d = lit_q;
            b_d = acc;
         end
         sse_pkg::SSE_OP_NONE: begin
            a_d = acc;
            b_d = reg_rdata;
         end
      endcase
      diff_d = {1'b0, a_d} - {1'b0, b_d} - {8'h00, bin_d};
      half_d = {1'b0, a_d[3:0]} - {1'b0, b_d[3:0]} - {4'h0, bin_d};
      ov_d = (a_d[7] != b_d[7]) && (diff_d[7] != a_d[7]);
   end

   // process in Q3, reading register data
   always_ff @(posedge clk) begin
      if (reset) begin
         res_q <= `SSE_ACC_RST;
      end else if (busy && phase_q == sse_pkg::SSE_Q3) begin
         res_q <= diff_d[7:0];
      end
   end

   // Flags settle in Q3, a cycle before the result lands
   // flags from the result
   always_ff @(posedge clk) begin
      if (reset) begin
         flag_n <= 1'b0;
         flag_ov <= 1'b0;
         flag_c <= 1'b0;
         flag_dc <= 1'b0;
         flag_z <= 1'b0;
      end else if (busy && phase_q == sse_pkg::SSE_Q3) begin
         flag_n <= diff_d[7];
         flag_ov <= ov_d;
         flag_c <= ~diff_d[8];
         flag_dc <= ~half_d[4];
         flag_z <= (diff_d[7:0] == 8'h00);
      end
   end

   // ----------------------------------------
   // Q4 write back
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         acc <= `SSE_ACC_RST;
         reg_wr <= 1'b0;
         reg_wdata <= 8'h00;
      end else begin
         reg_wr <= 1'b0;
         if (busy && phase_q == sse_pkg::SSE_Q4) begin
            if (dest_q) begin
               reg_wr <= 1'b1;
               reg_wdata <= res_q;
            end else begin
               acc <= res_q;
            end
         end
      end
   end

   // ----------------------------------------
   // Sleep and watchdog
   // ----------------------------------------
   // Sleep needs no operand fetch, so it acts in its decode cycle
   logic sleep_go;
   assign sleep_go = instr_valid && !busy && !sleeping && is_sleep;

   always_ff @(posedge clk) begin
      if (reset) begin
         power_down_flag <= 1'b1;
         watchdog_expiry_flag <= 1'b1;
      end else if (sleep_go) begin
         power_down_flag <= 1'b0;
         watchdog_expiry_flag <= 1'b1;
      end else if (sleeping && wdt_wake) begin
         watchdog_expiry_flag <= 1'b0;
      end
   end

   // ----------------------------------------
   // Watchdog stand-in
   // ----------------------------------------
   // Free-running count so that the sleep clear can be seen at the pins;
   // the real timeout source stays outside and arrives on wdt_wake
   always_ff @(posedge clk) begin
      if (reset) begin
         wdt_count <= `SSE_WDT_RST;
      end else if (sleep_go) begin
         wdt_count <= `SSE_WDT_RST;
      end else begin
         wdt_count <= wdt_count + 8'h01;
      end
   end

   // Postscaler steps once per count wrap
   always_ff @(posedge clk) begin
      if (reset) begin
         wdt_post <= `SSE_POST_RST;
      end else if (sleep_go) begin
         wdt_post <= `SSE_POST_RST;
      end else if (wdt_count == 8'hff) begin
         wdt_post <= wdt_post + 8'h01;
      end
   end

   // Wake only from sleep; a wake request while awake is ignored
   always_ff @(posedge clk) begin
      if (reset) begin
         sleeping <= 1'b0;
         osc_run <= 1'b1;
      end else if (sleep_go) begin
         sleeping <= 1'b1;
         osc_run <= 1'b0;
      end else if (sleeping && (wdt_wake || other_wake)) begin
         sleeping <= 1'b0;
         osc_run <= 1'b1;
      end
   end
endmodule

/* hw/sse_pkg.sv */
package sse_pkg;
   typedef enum logic [1:0] {
      SSE_Q1 = 2'b00,
      SSE_Q2 = 2'b01,
      SSE_Q3 = 2'b10,
      SSE_Q4 = 2'b11
   } sse_phase_t;
   typedef enum logic [1:0] {
      SSE_OP_NONE = 2'b00,
      SSE_OP_RBS_K = 2'b01,
      SSE_OP_RMA_K = 2'b10,
      SSE_OP_LMA_K = 2'b11
   } sse_op_t;
endpackage

/* hw/sse_regs.svh */
`ifndef SSE_REGS_SVH
`define SSE_REGS_SVH
`define SSE_OP_SLEEP 16'h0003
`define SSE_OP_RBS 6'h15
`define SSE_OP_RMA 6'h17
`define SSE_OP_LMA 8'h08
`define SSE_ILO_MAX 8'h5f
`define SSE_ACC_RST 8'h00
`define SSE_WDT_RST 8'h00
`define SSE_POST_RST 8'h00
`endif

/* sim/sse_core_asserts.sv */
`timescale 1ns/1ns
module sse_chk (
   input wire logic clk,
   input wire logic reset,
   input wire logic [15:0] instr,
   input wire logic instr_valid,
   input wire logic [3:0] bank_select,
   input wire logic wdt_wake,
   input wire logic [11:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic power_down_flag,
   input wire logic watchdog_expiry_flag,
   input wire logic [7:0] wdt_count,
   input wire logic osc_run,
   input wire logic sleeping,
   input wire logic busy
);
   // ----------------------------
   // Decode of accepted requests
   // ----------------------------
   wire tk = instr_valid && !busy && !sleeping;
   wire sub = tk && instr[15:12] == 4'h5 && instr[10];
   wire lit = tk && instr[15:8] == 8'h08;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   chk_sleep_status: assert property (
      tk && instr == 16'h0003 |=> !power_down_flag
      && watchdog_expiry_flag && wdt_count == 8'h00)
      else $error("sleep status wrong");
   chk_sleep_osc: assert property (
      tk && instr == 16'h0003 |=> sleeping && !osc_run)
      else $error("sleep entry wrong");
   chk_wdt_wake: assert property (
      sleeping && wdt_wake |=> !watchdog_expiry_flag && !sleeping)
      else $error("watchdog wake wrong");
   chk_four_phase: assert property (
      sub |=> busy [*3] ##1 !busy)
      else $error("subtract length wrong");
   chk_read_pulse: assert property (
      sub |-> ##2 reg_rd ##1 !reg_rd)
      else $error("read pulse wrong");
   chk_lit_noread: assert property (
      lit |=> !reg_rd [*4])
      else $error("literal read a register");
   chk_dest_reg: assert property (
      sub && instr[9] |-> ##4 reg_wr)
      else $error("no write back");
   chk_dest_acc: assert property (
      sub && !instr[9] |-> ##4 !reg_wr)
      else $error("stray write back");
   chk_bank_addr: assert property (
      sub && instr[8] |-> ##2 reg_addr[7:0] == $past(instr[7:0], 2)
      && reg_addr[11:8] == $past(bank_select, 2))
      else $error("bank address wrong");
endmodule
bind sse_core sse_chk u_chk (.clk(clk), .reset(reset), .instr(instr),
   .instr_valid(instr_valid), .bank_select(bank_select),
   .wdt_wake(wdt_wake), .reg_addr(reg_addr), .reg_rd(reg_rd),
   .reg_wr(reg_wr), .power_down_flag(power_down_flag),
   .watchdog_expiry_flag(watchdog_expiry_flag), .wdt_count(wdt_count),
   .osc_run(osc_run), .sleeping(sleeping), .busy(busy));

/* sim/tb.sv */
`timescale 1ns/1ns
module tb;
   logic clk, reset, iv, ext, ci, ww, ow, pb;
   logic [15:0] ins, w;
   logic [3:0] bs;
   logic [7:0] fb, fv, am, rdat, wd, acc, wc, wp;
   logic [11:0] ea, ra;
   logic rd, wr, fn, fo, fc, fd, fz, pd, to, osc, slp, busy;
   logic [13:0] eq[$];
   int err_total, checked;
   // Wrong address returns inverted data
   assign rdat = (ra === ea) ? fv : ~fv;
   sse_core DUT (.clk(clk), .reset(reset), .instr(ins), .instr_valid(iv),
      .ext_set_en(ext), .bank_select(bs), .fsr2_base(fb), .reg_rdata(rdat),
      .carry_in(ci), .wdt_wake(ww), .other_wake(ow), .reg_addr(ra),
      .reg_rd(rd), .reg_wr(wr), .reg_wdata(wd), .acc(acc), .flag_n(fn),
      .flag_ov(fo), .flag_c(fc), .flag_dc(fd), .flag_z(fz),
      .power_down_flag(pd), .watchdog_expiry_flag(to), .wdt_count(wc),
      .wdt_post(wp), .osc_run(osc), .sleeping(slp), .busy(busy));
   task automatic check(input logic [23:0] s, input logic [23:0] e);
      checked++;
      if (s !== e) begin
         err_total++;
         $display("unexpected at %0t: %h vs %h", $time, s, e);
      end
   endtask
   task automatic finish_test();
      $display("errors %0d checks %0d", err_total, checked);
      if (err_total == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Carry out of a + ~b + ci is the inverted borrow
   function automatic logic [13:0] sub(input logic [7:0] a, b,
      input logic c, d);
      logic [8:0] s;
      logic [4:0] h;
      s = {1'b0, a} + {1'b0, ~b} + 9'(c);
      h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'(c);
      return {d, s[7], a[7] != b[7] && s[7] != a[7], s[8], h[4],
         s[7:0] == 8'h00, s[7:0]};
   endfunction
   task automatic op(input logic [15:0] x);
      int n;
      logic [13:0] e;
      if (x[8]) ea = {bs, x[7:0]};
      else if (ext && x[7:0] <= 8'h5f) ea = {4'h0, fb + x[7:0]};
      else ea = {x[7] ? 4'hf : 4'h0, x[7:0]};
      fv = 8'($urandom);
      if (x[15:8] == 8'h08) e = sub(x[7:0], am, 1'b1, 1'b0);
      else if (x[11]) e = sub(fv, am, 1'b1, x[9]);
      else e = sub(am, fv, ci, x[9]);
      if (!e[13]) am = e[7:0];
      eq.push_back(e);
      ins = x;
      iv = 1'b1;
      tick(1);
      // Another valid word while busy must be ignored
      ins = 16'h5f00 | 16'($urandom_range(255));
      n = 0;
      while (busy !== 1'b0 && n < 20) begin
         tick(1);
         n++;
      end
      check(24'(n), 24'h3);
   endtask
   // -----------------------------------
   // Result monitor, fed by the driver
   // -----------------------------------
   always @(posedge clk) begin
      #2;
      if (pb === 1'b1 && busy === 1'b0) begin
         check({wr, fn, fo, fc, fd, fz, wr ? wd : acc},
            eq.size() ? eq.pop_front() : 14'h3fff);
      end
      pb = busy;
   end
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #100000;
      err_total++;
      finish_test();
   end
   initial begin
      logic [7:0] bnd [6] = '{8'h5f, 8'h60, 8'h80, 8'h7f, 8'h00, 8'hff};
      {iv, ext, ci, ww, ow, ins, bs, fb, am} = '0;
      reset = 1'b1;
      err_total = 0;
      checked = 0;
      fv = 8'($urandom(54688));
      tick(8);
      check({pd, to, osc, slp, busy, fn, fo, fc, fd, fz, acc}, 18'h38000);
      reset = 1'b0;
      for (int i = 0; i < 45; i++) begin
         ext = 1'($urandom);
         bs = 4'($urandom);
         fb = 8'($urandom_range(127));
         ci = 1'($urandom);
         w = {4'h5, (i % 3) ? 2'b11 : 2'b01, 2'($urandom), 8'($urandom)};
         if (i % 3 == 2) w = {8'h08, 8'($urandom)};
         // Edges of the offset window, access bank
         if (i < 6) begin
            ext = 1'b1;
            w[8] = 1'b0;
            w[7:0] = bnd[i];
         end
         op(w);
      end
      ins = 16'hffff;
      tick(6);
      check(busy, 1'b0);
      for (int k = 0; k < 2; k++) begin
         ins = 16'h0003;
         iv = 1'b1;
         tick(1);
         ins = 16'h5c10;
         check({pd, to, wc, wp, osc, slp}, 20'h40001);
         tick(3);
         check({busy, slp}, 2'b01);
         iv = 1'b0;
         {ww, ow} = k ? 2'b10 : 2'b01;
         tick(1);
         {ww, ow} = 2'b00;
         check({slp, to}, {1'b0, !k});
      end
      tick(4);
      finish_test();
   end
endmodule
